// ==== logic/fsm_pkg.sv ====
package fsm_pkg;
  // ==========================================
  // Slave address and memory layout
  localparam int ADDR_W = 15;
  localparam int MEM_DEPTH = 32768;
  localparam logic [3:0] DEV_TYPE_CODE = 4'h5; // Value arbitrary
  localparam logic [14:0] ADDR_RESET = 15'h0000;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // ==========================================
  // Protocol states
  typedef enum logic [2:0] {
    FSM_IDLE = 3'b000,
    FSM_SLAVE_ADDR = 3'b001,
    FSM_ADDR_HI = 3'b010,
    FSM_ADDR_LO = 3'b011,
    FSM_WRITE = 3'b100,
    FSM_READ = 3'b101
  } fsm_state_e;
endpackage : fsm_pkg

// ==== logic/fsm_i2c_slave.sv ====
`timescale 1ns/1ps
module fsm_i2c_slave
  import fsm_pkg::*;
(
  input wire logic MCLK, // System clock, 40 MHz
  input wire logic SRST, // Synchronous reset, active high
  input wire logic SCL_I, // Bus clock from master
  input wire logic SDA_I, // Bus data level
  output logic SDA_O, // Data driven value, always low when driving
  output logic SDA_OE, // High while pulling SDA low
  input wire logic [2:0] DEVICE_SELECT_PINS, // Device select pins
  input wire logic WP // Write protect, active high
);

  // ==========================================
  // Input synchronisers
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] wp_sync_reg;
  logic [5:0] sel_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;

  // Bus clock; idles high so no false edge follows reset
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      scl_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], SCL_I};
      scl_d_reg <= scl_sync_reg[1];
    end
  end

  // Bus data; same depth as the clock so edges keep their order
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sda_sync_reg <= 2'h3;
      sda_d_reg <= 1'b1;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], SDA_I};
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  // Write protect
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      wp_sync_reg <= 2'h0;
    end else begin
      wp_sync_reg <= {wp_sync_reg[0], WP};
    end
  end

  // Select pins, first stage low half, second stage high half
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sel_sync_reg <= 6'h00;
    end else begin
      sel_sync_reg <= {sel_sync_reg[2:0], DEVICE_SELECT_PINS};
    end
  end

  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] sel_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign wp_s = wp_sync_reg[1];
  assign sel_s = sel_sync_reg[5:3];
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Slave address check: type code, select pins
  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] sel);
    addr_match = (b[7:4] == DEV_TYPE_CODE) && (b[3:1] == sel);
  endfunction : addr_match

  // ==========================================
  // Bit engine state
  fsm_state_e state_reg;
  logic [3:0] bit_cnt_reg; // 0..7 data bits, 8 = ack clock
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic ack_pend_reg; // Device drives ack in the ninth clock
  logic rd_mode_reg; // Device is transmitting data
  logic [ADDR_W-1:0] addr_reg;
  logic [6:0] addr_hi_reg;
  logic sda_oe_reg;
  logic [7:0] mem [0:MEM_DEPTH-1];
  logic [7:0] rx_byte;

  assign rx_byte = {shift_reg[6:0], sda_s};

  // Bit counter
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      bit_cnt_reg <= 4'h0;
    end else if (start_det || stop_det) begin
      bit_cnt_reg <= 4'h0;
    end else if (scl_rise && state_reg != FSM_IDLE) begin
      bit_cnt_reg <= (bit_cnt_reg == 4'h8) ? 4'h0 : bit_cnt_reg + 4'h1;
    end
  end

  // Receive shifter
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      shift_reg <= 8'h00;
    end else if (start_det || stop_det) begin
      shift_reg <= shift_reg;
    end else if (scl_rise && state_reg != FSM_IDLE) begin
      shift_reg <= rx_byte;
    end
  end

  // Next latch value, rolls over from the top to zero
  function automatic logic [ADDR_W-1:0] addr_next(input logic [ADDR_W-1:0] a);
    addr_next = a + 15'h0001;
  endfunction : addr_next

  // ==========================================
  // Protocol sequence
  logic last_bit;
  assign last_bit = scl_rise && bit_cnt_reg == {1'b0, BIT_LAST};

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state_reg <= FSM_IDLE;
      ack_pend_reg <= 1'b0;
      rd_mode_reg <= 1'b0;
      addr_reg <= ADDR_RESET;
      addr_hi_reg <= 7'h00;
    end else if (start_det) begin
      state_reg <= FSM_SLAVE_ADDR;
      ack_pend_reg <= 1'b0;
      rd_mode_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= FSM_IDLE;
      ack_pend_reg <= 1'b0;
      rd_mode_reg <= 1'b0;
    end else if (last_bit && !rd_mode_reg) begin
      ack_pend_reg <= 1'b0;
      case (state_reg)
        FSM_SLAVE_ADDR: begin
          if (addr_match(rx_byte, sel_s)) begin
            ack_pend_reg <= 1'b1;
            state_reg <= rx_byte[0] ? FSM_READ : FSM_ADDR_HI;
          end else begin
            state_reg <= FSM_IDLE;
          end
        end
        FSM_ADDR_HI: begin
          addr_hi_reg <= rx_byte[6:0];
          ack_pend_reg <= 1'b1;
          state_reg <= FSM_ADDR_LO;
        end
        FSM_ADDR_LO: begin
          addr_reg <= {addr_hi_reg, rx_byte};
          ack_pend_reg <= 1'b1;
          state_reg <= FSM_WRITE;
        end
        FSM_WRITE: begin
          if (!wp_s) begin
            addr_reg <= addr_next(addr_reg);
            ack_pend_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
    end else if (last_bit && rd_mode_reg) begin
      addr_reg <= addr_next(addr_reg);
    end else if (scl_rise && bit_cnt_reg == 4'h8) begin
      if (rd_mode_reg) begin
        if (sda_s) begin
          state_reg <= FSM_IDLE;
          rd_mode_reg <= 1'b0;
        end
      end else if (!ack_pend_reg) begin
        state_reg <= FSM_IDLE;
      end else if (state_reg == FSM_READ) begin
        rd_mode_reg <= 1'b1;
      end
      ack_pend_reg <= 1'b0;
    end
  end

  // Memory write commits before the ack clock
  always_ff @(posedge MCLK) begin
    if (last_bit && !start_det && !stop_det && state_reg == FSM_WRITE && !rd_mode_reg && !wp_s) begin
      mem[addr_reg] <= rx_byte;
    end
  end

  // ==========================================
  // SDA driver, changes after SCL falls
  logic bit_phase_ack;
  assign bit_phase_ack = bit_cnt_reg == 4'h8;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      tx_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_oe_reg <= 1'b0;
    end else if (scl_fall) begin
      if (bit_phase_ack && !rd_mode_reg) begin
        sda_oe_reg <= ack_pend_reg;
      end else if (bit_phase_ack && rd_mode_reg) begin
        sda_oe_reg <= 1'b0;
      end else if (bit_cnt_reg == 4'h0 && rd_mode_reg) begin
        tx_reg <= {mem[addr_reg][6:0], 1'b0};
        sda_oe_reg <= ~mem[addr_reg][7];
      end else if (rd_mode_reg) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
        sda_oe_reg <= ~tx_reg[7];
      end else begin
        sda_oe_reg <= 1'b0;
      end
    end
  end

  // Open drain: only ever pull low, SCL never driven
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      SDA_O <= 1'b0;
    end else begin
      SDA_O <= 1'b0;
    end
  end

  // Enable pin straight from a flop
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      SDA_OE <= 1'b0;
    end else begin
      SDA_OE <= sda_oe_reg;
    end
  end

endmodule : fsm_i2c_slave

// ==== testbench/fsm_i2c_properties.sv ====
`timescale 1ns/1ps
module fsm_i2c_checker (
  input wire logic MCLK, // System clock
  input wire logic SRST, // Sync reset
  input wire logic SCL_I, // Bus clock
  input wire logic SDA_I, // Data wire
  input wire logic SDA_O, // Data value
  input wire logic SDA_OE, // Pull-down enable
  input wire logic [2:0] DEVICE_SELECT_PINS, // Select pins
  input wire logic WP // Write protect
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (SRST);
  // ==========
  // Pin timing
  value_low_a: assert property (!SDA_O) else $error("data value high");
  reset_off_a: assert property (disable iff (1'b0) SRST |=> !SDA_OE) else $error("drive in reset");
  reset_quiet_a: assert property ($fell(SRST) |-> !SDA_OE [*8]) else $error("drive after reset");
  low_phase_a: assert property ($changed(SDA_OE) |-> !SCL_I && !$past(SCL_I, 3)) else $error("late change");
  high_hold_a: assert property ($rose(SCL_I) |=> $stable(SDA_OE) [*3]) else $error("change at high");
  bit_width_a: assert property ($rose(SDA_OE) |-> SDA_OE [*6]) else $error("short drive");
  stop_idle_a: assert property (SCL_I && $rose(SDA_I) |=> !SDA_OE [*8]) else $error("drive after stop");
  start_idle_a: assert property (SCL_I && $fell(SDA_I) |=> !SDA_OE [*8]) else $error("drive after start");
endmodule : fsm_i2c_checker
bind fsm_i2c_slave fsm_i2c_checker chk_u (.MCLK(MCLK), .SRST(SRST), .SCL_I(SCL_I), .SDA_I(SDA_I),
  .SDA_O(SDA_O), .SDA_OE(SDA_OE), .DEVICE_SELECT_PINS(DEVICE_SELECT_PINS), .WP(WP));

// ==== testbench/fsm_i2c_master.sv ====
`timescale 1ns/1ps
module fsm_i2c_master (
  output logic scl, // Bus clock
  output logic sda_oe, // High while pulling SDA low
  input wire logic sda, // Resolved data wire
  output logic res_v, // Pulse per byte
  output logic [8:0] res // Byte seen and ninth bit
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
    res_v = 1'b0;
    res = 9'h000;
  end
  // ==========
  // Bus cycles, data moves while clock low except in start and stop
  task automatic bit_io(input logic b, output logic r);
    sda_oe = !b;
    #75 scl = 1'b1;
    #25 r = sda;
    #25 scl = 1'b0;
    #75;
  endtask : bit_io
  task automatic start();
    sda_oe = 1'b0;
    #100 scl = 1'b1;
    #100 sda_oe = 1'b1;
    #100 scl = 1'b0;
    #50;
  endtask : start
  task automatic stop();
    sda_oe = 1'b1;
    #50 scl = 1'b1;
    #100 sda_oe = 1'b0;
    #100;
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic a);
    logic [8:0] r;
    for (int i = 8; i >= 0; i--) bit_io(i > 0 ? d[i-1] : a, r[i]);
    res = r;
    res_v = 1'b1;
    // Pulse must not shift the bus timing off the clock phase
    res_v <= #1 1'b0;
  endtask : xfer
endmodule : fsm_i2c_master

// ==== testbench/fsm_i2c_slave_tb.sv ====
`timescale 1ns/1ps
module fsm_i2c_slave_tb
  import fsm_pkg::*;
;
  logic mclk, srst, wp, oe, m_oe, scl, res_v;
  logic [2:0] sel;
  logic [8:0] res;
  logic [8:0] exp_q[$];
  logic [7:0] mem[int];
  logic [14:0] cur;
  int seed = 54754;
  int mismatches = 0;
  int total_checks = 0;
  wire sda = !(oe || m_oe);
  fsm_i2c_slave dut_u (.MCLK(mclk), .SRST(srst), .SCL_I(scl), .SDA_I(sda), .SDA_O(), .SDA_OE(oe),
    .DEVICE_SELECT_PINS(sel), .WP(wp));
  fsm_i2c_master m_u (.scl(scl), .sda_oe(m_oe), .sda(sda), .res_v(res_v), .res(res));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ==========
  // Bus tasks
  task automatic xf(input logic [7:0] d, input logic a, input logic [8:0] e);
    exp_q.push_back(e);
    m_u.xfer(d, a);
  endtask : xf
  task automatic head(input logic rw);
    m_u.start();
    xf({DEV_TYPE_CODE, sel, rw}, 1'b1, {DEV_TYPE_CODE, sel, rw, 1'b0});
  endtask : head
  task automatic wr(input logic [15:0] a, input int n);
    logic [7:0] d;
    head(1'b0);
    xf(a[15:8], 1'b1, {a[15:8], 1'b0});
    xf(a[7:0], 1'b1, {a[7:0], 1'b0});
    cur = a[14:0];
    repeat (n) begin
      d = 8'($random(seed));
      xf(d, 1'b1, {d, wp});
      if (!wp) begin
        mem[cur] = d;
        cur++;
      end
    end
  endtask : wr
  task automatic rd(input int n);
    head(1'b1);
    for (int i = 0; i < n; i++) begin
      xf(8'hff, i == n - 1, {mem[cur], i == n - 1});
      cur++;
    end
  endtask : rd
  task automatic chk(input logic [8:0] e, input logic [8:0] s);
    total_checks++;
    if (s !== e) begin
      $display("[ERR] byte_ack expected %h seen %h", e, s);
      mismatches++;
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial forever begin
    @(posedge res_v);
    chk(exp_q.pop_front(), res);
  end
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
  initial begin
    srst = 1'b1;
    wp = 1'b0;
    sel = 3'h0;
    repeat (16) @(posedge mclk);
    #2 srst = 1'b0;
    sel = 3'($random(seed));
    repeat (4) @(posedge mclk);
    #2;
    wr(16'hfffe, 4);
    m_u.stop();
    wr(16'h7ffe, 0);
    rd(3);
    m_u.stop();
    rd(1);
    m_u.stop();
    @(posedge mclk) #2 wp = 1'b1;
    wr(16'h0000, 1);
    m_u.stop();
    @(posedge mclk) #2 wp = 1'b0;
    rd(1);
    m_u.stop();
    m_u.start();
    xf({DEV_TYPE_CODE ^ 4'h8, sel, 1'b1}, 1'b1, {DEV_TYPE_CODE ^ 4'h8, sel, 2'b11});
    m_u.start();
    xf({DEV_TYPE_CODE, ~sel, 1'b1}, 1'b1, {DEV_TYPE_CODE, ~sel, 2'b11});
    m_u.stop();
    give_verdict();
  end
endmodule : fsm_i2c_slave_tb
